// ---- scc_pkg.sv ----
// scc_pkg: constants, field layouts and carrier types of the sampling-clock sync control
// assumes a 16-bit register map reached through a 24-bit serial control frame
package scc_pkg;

	// register offsets (4-bit serial address)
	localparam logic [3:0]  ADDR_COARSE       = 4'hc;
	localparam logic [3:0]  ADDR_FINE         = 4'hd;
	localparam logic [3:0]  ADDR_SYNC         = 4'he;

	// power-on values
	localparam logic [15:0] RST_COARSE        = 16'h0004;
	localparam logic [15:0] RST_FINE          = 16'h0000;
	localparam logic [15:0] RST_SYNC          = 16'h0003;

	// coarse register field
	localparam int          POS_DLY_SEL       = 3;
	// fine register fields
	localparam int          POS_FINE_LSB      = 10;
	localparam int          POS_DLY_SEL_ALT   = 8;
	localparam logic [15:0] FINE_WR_MASK      = 16'hfd00;
	// sync control fields
	localparam int          POS_REF_DLY_LSB   = 7;
	localparam int          POS_DUAL_EDGE     = 6;
	localparam int          POS_PHASE_LSB     = 3;
	localparam int          POS_SLAVE         = 2;
	localparam int          POS_REF_OUT_DIS   = 1;
	localparam int          POS_RST_DIS       = 0;

	// reference delay code saturation: 1200 ps at code 319
	localparam logic [8:0]  REF_DLY_MAX       = 9'h13f;
	localparam int          REF_DLY_MAX_PS    = 1200;
	// fine delay step in femtoseconds
	localparam logic [5:0]  FINE_STEP_FS      = 6'h24;

	// serial frame layout
	localparam int          FRAME_BITS        = 24;
	localparam logic [4:0]  CMD_LAST_BIT      = 5'h07;
	localparam logic [4:0]  FRAME_LAST_BIT    = 5'h17;
	localparam int          POS_FRAME_RD      = 23;
	localparam int          POS_FRAME_ADDR    = 16;

	typedef enum logic [1:0] {FR_IDLE, FR_CMD, FR_DATA, FR_DONE} scc_fr_state_t;

	// decoded sync control register
	typedef struct packed {
		logic [8:0] ref_clock_delay_code;
		logic       dual_edge_iq_mode;
		logic       reserved5;
		logic [1:0] ref_phase_select;
		logic       slave_enable;
		logic       ref_output_disable;
		logic       out_clock_reset_disable;
	} scc_sync_t;

	// settings applied to the converter's clock path
	typedef struct packed {
		logic [8:0]  ref_delay_code;
		logic        dual_edge_iq_enable;
		logic        slave_mode;
		logic        delay_adjust_en;
		logic [5:0]  fine_delay_code;
		logic [11:0] fine_delay_fs;
	} scc_applied_t;

endpackage : scc_pkg

// ---- scc_div4.sv ----
// scc_div4: divide-by-four phase counter of the internal divided clocks
// assumes align and hold are synchronous to ref_clk
`timescale 1ns/100ps
module scc_div4 import scc_pkg::*; #(
	parameter int W = 2
) (
	input  wire logic         ref_clk,  // sampling clock
	input  wire logic         arst_n,   // async reset
	input  wire logic         clk_en,   // state freeze when low
	input  wire logic         align,    // restart phase at zero
	input  wire logic         hold,     // hold phase at zero
	output logic      [W-1:0] phase     // divided-clock phase
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	assign nxt_cnt = (align || hold) ? '0 : cnt_ff + W'(1);
	assign phase   = cnt_ff;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
		end else if (clk_en) begin
			cnt_ff <= nxt_cnt;
		end
	end

endmodule : scc_div4

// ---- scc_ctrl.sv ----
// scc_ctrl: sampling-clock fine delay and multi-converter clock sync control
// assumes serial port pins and the reference input are synchronous to ref_clk
`timescale 1ns/100ps
module scc_ctrl import scc_pkg::*; (
	input  wire logic        ref_clk,          // sampling clock, 10 MHz
	input  wire logic        arst_n,           // async reset, active low
	input  wire logic        clk_en,           // freezes all state when low
	input  wire logic        spi_cs_n,         // serial select, active low
	input  wire logic        spi_sclk,         // serial clock, sampled
	input  wire logic        spi_din,          // serial data in
	output logic             spi_dout,         // serial data out
	output logic             spi_dout_oe_n,    // low while dout driven
	input  wire logic        ref_clock_in,     // reference from master
	input  wire logic        out_clock_reset,  // output-clock reset request
	output logic             ref_clock_out_a,  // reference out a
	output logic             ref_clock_out_b,  // reference out b
	output logic             ref_out_oe_n,     // low while ref outputs driven
	output logic       [1:0] div_phase,        // internal divided-clock phase
	output scc_applied_t     applied           // settings to the clock path
);
	scc_fr_state_t state_ff;
	scc_fr_state_t nxt_state;
	logic [15:0]   coarse_ff;
	logic [15:0]   fine_ff;
	logic [15:0]   sync_ff;
	logic          sclk_ff;
	logic [4:0]    bit_cnt_ff;
	logic [22:0]   sh_in_ff;
	logic [15:0]   sh_out_ff;
	logic          rd_ff;
	logic          dout_ff;
	logic [3:0]    ref_tap_ff;
	logic          ref_lat_ff;
	logic          ref_a_ff;
	logic          ref_b_ff;
	scc_applied_t  applied_ff;

	// serial decode
	// sclk is oversampled, edges are found against the previous sample
	wire                  sclk_rise  = spi_sclk && !sclk_ff;
	wire                  sclk_fall  = !spi_sclk && sclk_ff;
	wire [FRAME_BITS-1:0] frame      = {sh_in_ff, spi_din};
	wire                  cmd_done   = sclk_rise && (bit_cnt_ff == CMD_LAST_BIT);
	wire                  frame_done = sclk_rise && (bit_cnt_ff == FRAME_LAST_BIT);
	wire [3:0]            cmd_addr   = frame[3:0];
	wire [3:0]            wr_addr    = frame[POS_FRAME_ADDR +: 4];
	wire                  wr_go      = frame_done && !frame[POS_FRAME_RD];
	wire                  wr_coarse  = wr_go && (wr_addr == ADDR_COARSE);
	wire                  wr_fine    = wr_go && (wr_addr == ADDR_FINE);
	wire                  wr_sync    = wr_go && (wr_addr == ADDR_SYNC);
	wire [15:0]           wr_data    = frame[15:0];

	// read mux, unmapped addresses read zero
	wire [15:0] rd_data = (cmd_addr == ADDR_COARSE) ? coarse_ff :
	                      (cmd_addr == ADDR_FINE)   ? fine_ff   :
	                      (cmd_addr == ADDR_SYNC)   ? sync_ff   : 16'h0000;

	// sync register fields
	scc_sync_t sync_f;
	assign sync_f = scc_sync_t'(sync_ff);

	// codes at or above the top step clamp instead of wrapping
	wire [8:0] ref_dly_sat = (sync_f.ref_clock_delay_code >= REF_DLY_MAX) ?
	                         REF_DLY_MAX : sync_f.ref_clock_delay_code;
	// either select bit, coarse or fine register, opens the fine delay
	wire       dly_en  = coarse_ff[POS_DLY_SEL] || fine_ff[POS_DLY_SEL_ALT];
	wire [5:0] fine_cd = dly_en ? fine_ff[POS_FINE_LSB +: 6] : 6'h00;

	// widen both factors first, a 6-bit product would drop the upper bits
	wire [11:0] fine_cd_w = 12'(fine_cd);
	wire [11:0] fine_stp  = 12'(FINE_STEP_FS);
	wire [11:0] fine_fs   = fine_cd_w * fine_stp;

	scc_applied_t nxt_applied;
	always_comb begin
		nxt_applied                     = '0;
		nxt_applied.ref_delay_code      = ref_dly_sat;
		nxt_applied.dual_edge_iq_enable = sync_f.dual_edge_iq_mode;
		nxt_applied.slave_mode          = sync_f.slave_enable;
		nxt_applied.delay_adjust_en     = dly_en;
		nxt_applied.fine_delay_code     = fine_cd;
		nxt_applied.fine_delay_fs       = fine_fs;
	end

	// reference phase latch and slave alignment
	wire       ref_sel   = ref_tap_ff[sync_f.ref_phase_select];
	wire       ref_edge  = ref_sel && !ref_lat_ff;
	wire       div_align = sync_f.slave_enable && ref_edge;
	// output-clock reset only acts once its disable bit is cleared
	wire       div_hold  = !sync_f.out_clock_reset_disable && out_clock_reset;
	wire       ref_drive = !sync_f.ref_output_disable;
	wire [1:0] phase;

	// divided clocks run free as master, restart on the latched reference as slave
	scc_div4 #(
		.W (2)
	) u_div (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.clk_en  (clk_en),
		.align   (div_align),
		.hold    (div_hold),
		.phase   (phase)
	);

	// serial state sequence
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			FR_IDLE: begin
				if (!spi_cs_n) nxt_state = FR_CMD;
			end
			FR_CMD: begin
				if (spi_cs_n) nxt_state = FR_IDLE;
				else if (cmd_done) nxt_state = FR_DATA;
			end
			FR_DATA: begin
				if (spi_cs_n) nxt_state = FR_IDLE;
				else if (frame_done) nxt_state = FR_DONE;
			end
			FR_DONE: begin
				if (spi_cs_n) nxt_state = FR_IDLE;
			end
			default: nxt_state = FR_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= FR_IDLE;
			// idles low like the pin, so reset leaves no false edge
			sclk_ff  <= 1'b0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			sclk_ff  <= spi_sclk;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_ff <= 5'h00;
			sh_in_ff   <= '0;
		end else if (clk_en) begin
			if (spi_cs_n) begin
				bit_cnt_ff <= 5'h00;
			end else if (sclk_rise && state_ff != FR_DONE) begin
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
				sh_in_ff   <= frame[22:0];
			end
		end
	end

	// read data shifts out on falling sclk after the command byte
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_ff     <= 1'b0;
			sh_out_ff <= 16'h0000;
			dout_ff   <= 1'b0;
		end else if (clk_en) begin
			if (spi_cs_n) begin
				rd_ff <= 1'b0;
			end else if (cmd_done) begin
				rd_ff     <= frame[7];
				sh_out_ff <= rd_data;
			end else if (sclk_fall && state_ff == FR_DATA) begin
				dout_ff   <= sh_out_ff[15];
				sh_out_ff <= {sh_out_ff[14:0], 1'b0};
			end
		end
	end

	// registers
	// reserved bits of coarse and sync are stored as written, fine register reserved bits are masked to zero; software keeps their power-on values
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			coarse_ff <= RST_COARSE;
			fine_ff   <= RST_FINE;
			sync_ff   <= RST_SYNC;
		end else if (clk_en) begin
			if (wr_coarse) coarse_ff <= wr_data;
			if (wr_fine)   fine_ff   <= wr_data & FINE_WR_MASK;
			if (wr_sync)   sync_ff   <= wr_data;
		end
	end

	// reference taps, one ref_clk cycle is 90 degrees of the clock/4 reference
	// tap k holds the reference delayed k+1 cycles
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_tap_ff <= 4'h0;
			ref_lat_ff <= 1'b0;
			ref_a_ff   <= 1'b0;
			ref_b_ff   <= 1'b0;
			applied_ff <= '0;
		end else if (clk_en) begin
			ref_tap_ff <= {ref_tap_ff[2:0], ref_clock_in};
			ref_lat_ff <= ref_sel;
			ref_a_ff   <= ref_drive && phase[1];
			ref_b_ff   <= ref_drive && phase[1];
			applied_ff <= nxt_applied;
		end
	end

	assign spi_dout        = dout_ff;
	assign spi_dout_oe_n   = !(rd_ff && state_ff == FR_DATA);
	assign ref_clock_out_a = ref_a_ff;
	assign ref_clock_out_b = ref_b_ff;
	assign ref_out_oe_n    = sync_f.ref_output_disable;
	assign div_phase       = phase;
	assign applied         = applied_ff;

endmodule : scc_ctrl

// ---- scc_ref_master.sv ----
// scc_ref_master: master converter model driving the shared reference clock
// assumes run is changed just after a ref_clk edge
`timescale 1ns/100ps
module scc_ref_master (
	input  wire logic ref_clk,   // sampling clock
	input  wire logic arst_n,    // async reset, active low
	input  wire logic run,       // master reference running
	output logic      ref_clock  // clock/4 reference
);
	logic [1:0] cnt_ff;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) cnt_ff <= 2'h1;
		else if (run) cnt_ff <= cnt_ff + 2'h1;
	end
	// a stopped master parks its driver low
	assign ref_clock = run & cnt_ff[1];
endmodule : scc_ref_master

// ---- scc_ctrl_props.sv ----
// scc_ctrl_props: port assertions for scc_ctrl
// assumes a single ref_clk domain, bound to every scc_ctrl
`timescale 1ns/100ps
module scc_ctrl_props import scc_pkg::*; (
	input wire logic         ref_clk,          // sampling clock
	input wire logic         arst_n,           // async reset
	input wire logic         clk_en,           // state enable
	input wire logic         out_clock_reset,  // output-clock reset request
	input wire logic         ref_clock_out_a,  // reference out a
	input wire logic         ref_clock_out_b,  // reference out b
	input wire logic         ref_out_oe_n,     // reference out enable
	input wire logic   [1:0] div_phase,        // divided-clock phase
	input wire scc_applied_t applied           // applied settings
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_free;
		clk_en && !out_clock_reset && !applied.slave_mode;
	endsequence
	AST_OUT_FOLLOW: assert property (clk_en && !ref_out_oe_n |=>
		ref_clock_out_a == $past(div_phase[1])) else $error("ref out not phase bit");
	AST_OUT_SAME: assert property (ref_clock_out_a == ref_clock_out_b)
		else $error("ref outs differ");
	AST_OUT_OFF: assert property (clk_en && ref_out_oe_n |=> !ref_clock_out_a)
		else $error("ref out active while disabled");
	AST_MASTER_FREE: assert property (s_free |=> applied.slave_mode ||
		div_phase == $past(div_phase) + 2'h1) else $error("master phase jumped");
	AST_REF_DLY_SAT: assert property (applied.ref_delay_code <= 9'h13f)
		else $error("delay code above max");
	AST_FINE_FS: assert property (applied.fine_delay_fs ==
		{6'h00, applied.fine_delay_code} * 12'h024) else $error("fine fs wrong");
	AST_FINE_GATE: assert property (!applied.delay_adjust_en |->
		applied.fine_delay_code == 6'h00) else $error("fine code not gated");
	AST_RST_VAL: assert property ($rose(arst_n) |-> ref_out_oe_n &&
		applied == '0) else $error("bad value after reset");
endmodule : scc_ctrl_props
bind scc_ctrl scc_ctrl_props i_scc_ctrl_props (.ref_clk, .arst_n, .clk_en, .out_clock_reset,
	.ref_clock_out_a, .ref_clock_out_b, .ref_out_oe_n, .div_phase, .applied);

// ---- sampling_clock_sync_control_test.sv ----
// sampling_clock_sync_control_test: serial-register bench for scc_ctrl
// assumes scc_ref_master drives the reference input
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module sampling_clock_sync_control_test import scc_pkg::*;;
	logic         ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, spi_cs_n = 1'b1;
	logic         spi_sclk = 1'b0, spi_din = 1'b0, out_clock_reset = 1'b0, run = 1'b0;
	logic         spi_dout, spi_dout_oe_n, ref_clock_in, out_a, out_b, oe_n;
	logic   [1:0] div_phase, ph0, ph;
	logic  [15:0] rd;
	logic   [8:0] codes[5] = '{9'h000, 9'h13e, 9'h13f, 9'h140, 9'h1ff};
	scc_applied_t applied;
	int           errors = 0, num_checks = 0;
	logic   [3:0] hi, hb;
	logic         oe_seen;
	always #50 ref_clk = ~ref_clk;
	scc_ctrl i_scc_ctrl (.ref_clk, .arst_n, .clk_en, .spi_cs_n, .spi_sclk, .spi_din,
		.spi_dout, .spi_dout_oe_n, .ref_clock_in, .out_clock_reset,
		.ref_clock_out_a(out_a), .ref_clock_out_b(out_b), .ref_out_oe_n(oe_n),
		.div_phase, .applied);
	scc_ref_master i_scc_ref_master (.ref_clk, .arst_n, .run, .ref_clock(ref_clock_in));
	task automatic tick(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	// one 24-bit frame, msb first, read data collected after the low halves of bits 16 to 1
	task automatic xfer(input logic [23:0] f);
		spi_cs_n = 1'b0;
		tick();
		for (int i = 23; i >= 0; i--) begin
			spi_din = f[i];
			spi_sclk = 1'b1;
			tick(2);
			spi_sclk = 1'b0;
			tick(2);
			if (i > 0 && i < 17) rd[i-1] = spi_dout;
			if (i == 8) oe_seen = spi_dout_oe_n;
		end
		spi_cs_n = 1'b1;
		tick(3);
	endtask : xfer
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		xfer({4'h0, a, d});
		`CHK("dout_oe", 1'b1, oe_seen)
	endtask : wr
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		xfer({4'h8, a, 16'h0000});
		`CHK("reg", e, rd)
		`CHK("dout_oe", 1'b0, oe_seen)
	endtask : rchk
	// divider phase seen at a rising reference edge
	task automatic meas(output logic [1:0] p);
		logic prev;
		prev = ref_clock_in;
		for (int n = 0; n < 12; n++) begin
			tick();
			if (ref_clock_in && !prev) begin
				p = div_phase;
				return;
			end
			prev = ref_clock_in;
		end
		errors++;
		final_report();
	endtask : meas
	initial begin
		tick(12);
		`CHK("oe", 1'b1, oe_n)
		`CHK("out", 1'b0, out_a)
		arst_n = 1'b1;
		tick(2);
		rchk(4'he, 16'h0003);
		rchk(4'hd, 16'h0000);
		rchk(4'hc, 16'h0004);
		rchk(4'h5, 16'h0000);
		out_clock_reset = 1'b1;
		tick();
		ph0 = div_phase;
		tick();
		`CHK("free", ph0 + 2'h1, div_phase)
		clk_en = 1'b0;
		ph0 = div_phase;
		tick(3);
		`CHK("freeze", ph0, div_phase)
		clk_en = 1'b1;
		wr(4'he, 16'h0002);
		`CHK("hold", 2'h0, div_phase)
		out_clock_reset = 1'b0;
		wr(4'he, 16'h0000);
		`CHK("oe", 1'b0, oe_n)
		hi = 4'h0;
		hb = 4'h0;
		repeat (8) begin
			tick();
			hi += out_a;
			hb += out_b;
		end
		`CHK("duty", 4'h4, hi)
		`CHK("duty_b", 4'h4, hb)
		foreach (codes[i]) begin
			wr(4'he, {codes[i], 7'h03});
			rchk(4'he, {codes[i], 7'h03});
			`CHK("ref_dly", codes[i] > 9'h13f ? 9'h13f : codes[i], applied.ref_delay_code)
		end
		wr(4'h0, 16'h0000);
		wr(4'he, 16'h0043);
		`CHK("dual", 1'b1, applied.dual_edge_iq_enable)
		run = 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(4'he, {9'h000, 2'h0, k[1:0], 3'h5});
			`CHK("slave", 1'b1, applied.slave_mode)
			`CHK("oe", 1'b0, oe_n)
			meas(ph);
			if (k == 0) ph0 = ph;
			`CHK("phase", ph0 - k[1:0], ph)
		end
		wr(4'he, 16'h0003);
		`CHK("master", 1'b0, applied.slave_mode)
		`CHK("oe", 1'b1, oe_n)
		wr(4'hd, 16'hffff);
		rchk(4'hd, 16'hfd00);
		`CHK("fs", 12'h8dc, applied.fine_delay_fs)
		wr(4'hd, 16'hfc00);
		`CHK("off", 6'h00, applied.fine_delay_code)
		wr(4'hc, 16'h000c);
		`CHK("coarse", 6'h3f, applied.fine_delay_code)
		final_report();
	end
endmodule : sampling_clock_sync_control_test
